// *** src/hls_pkg.sv ***
// Package with constants and types of the hardware loop sequencer.
package hls_pkg;
    // Loop counter stack depth and count width.
    localparam int STACK_DEPTH = 6;
    localparam int COUNT_W     = 32;
    // Value read from the current count when the stack is empty.
    localparam logic [31:0] EMPTY_READ = 32'hffff_ffff;
    // Reset value of the loop count load register.
    localparam logic [31:0] LOAD_RESET = 32'h0000_0000;
    // Latency of the not-expired condition, in machine cycles.
    localparam int BRANCH_COND_LAT = 2;
    localparam int OTHER_COND_LAT  = 1;
    // Latency from a multiplier status change to an arithmetic loop abort.
    localparam int MULT_ABORT_LAT = 1;
    // Loop termination kinds.
    typedef enum logic [2:0] {
        HLS_KIND_COUNT   = 3'b001,
        HLS_KIND_ARITH   = 3'b010,
        HLS_KIND_FOREVER = 3'b100
    } hls_kind_e;
endpackage : hls_pkg

// *** src/hls_stack_mem.sv ***
// Small register-file memory holding loop counter stack entries.
`timescale 1ns/1ps
`default_nettype none
module hls_stack_mem #(
    parameter int DEPTH = 6,
    parameter int WIDTH = 32,
    parameter int AW    = 3
) (
    // Clock.
    input  wire logic             ref_clk,
    // Write port.
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read port, registered.
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    // Refuses a depth that the address width cannot reach.
    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
        $error("hls_stack_mem: depth exceeds address range");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];

    // Stores one entry per write.
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // Registers the read data.
    always_ff @(posedge ref_clk) begin
        rd_data <= mem_q[rd_addr];
    end
endmodule : hls_stack_mem
`default_nettype wire

// *** src/hls_sequencer.sv ***
// Hardware loop sequencer: loop counter stack, termination tests and flush.
`timescale 1ns/1ps
`default_nettype none
module hls_sequencer
#(
    parameter int DEPTH   = hls_pkg::STACK_DEPTH,
    parameter int COUNT_W = hls_pkg::COUNT_W
) (
    // Clock and reset.
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Loop count load register write.
    input  wire logic                 loop_count_load_we,
    input  wire logic [COUNT_W-1:0]   loop_count_load_wdata,
    output logic      [COUNT_W-1:0]   loop_count_load,
    // Loop setup.
    input  wire logic                 setup_valid,
    input  wire hls_pkg::hls_kind_e   setup_kind,
    input  wire logic                 setup_single,
    // Current count access by the core.
    input  wire logic                 cur_we,
    input  wire logic [COUNT_W-1:0]   cur_wdata,
    output logic      [COUNT_W-1:0]   current_loop_count,
    // Pipeline events.
    input  wire logic                 stall,
    input  wire logic                 end_fetch,
    input  wire logic                 second_fetch,
    input  wire logic                 term_cond,
    input  wire logic                 mult_status_chg,
    input  wire logic                 stack_pop,
    // Results to the fetch unit and stacks.
    output logic                      not_expired_branch,
    output logic                      not_expired_other,
    output logic                      loop_exit,
    output logic                      flush_fetch,
    output logic                      pop_stacks,
    output logic                      arith_loop_abort,
    output logic                      stack_empty,
    output logic                      stack_overflow
);
    import hls_pkg::*;

    localparam int AW = $clog2(DEPTH + 1);

    // Refuses sizes that the all-ones empty read and the pointer cannot serve.
    if (DEPTH < 1 || COUNT_W < 2 || COUNT_W > 32) begin : g_bad_params
        $error("hls_sequencer: unsupported depth or width");
    end

    // ****************************************************************
    // Loop stack bookkeeping
    // ****************************************************************

    logic [AW-1:0]      sp_q;
    logic [COUNT_W-1:0] top_q;
    logic [COUNT_W-1:0] mem_rd;
    hls_kind_e          kind_q;
    hls_kind_e          kind_save_q [DEPTH];
    logic               single_q;
    logic               pop_now;
    logic               do_push;
    logic [AW-1:0]      rd_addr;
    logic               refill_q;

    // Returns one step below a stack pointer, saturating at zero.
    function automatic logic [AW-1:0] dec_ptr(input logic [AW-1:0] p);
        dec_ptr = (p == '0) ? '0 : p - AW'(1);
    endfunction : dec_ptr

    assign stack_empty = (sp_q == '0);
    assign do_push     = setup_valid;
    assign pop_now     = (pop_stacks || stack_pop) && !stack_empty;
    assign rd_addr     = dec_ptr(dec_ptr(sp_q));

    // Spilled entries below the top live in the memory.
    hls_stack_mem #(
        .DEPTH (DEPTH),
        .WIDTH (COUNT_W),
        .AW    (AW)
    ) u_mem (
        .ref_clk (ref_clk),
        .wr_en   (do_push && !stack_empty && sp_q < AW'(DEPTH)),
        .wr_addr (dec_ptr(sp_q)),
        .wr_data (refill_q ? mem_rd : top_q), // A push right after a pop saves the refilled top.
        .rd_addr (rd_addr),
        .rd_data (mem_rd)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sp_q <= '0;
        end else if (do_push && sp_q < AW'(DEPTH)) begin
            sp_q <= sp_q + AW'(1);
        end else if (pop_now && !do_push) begin
            sp_q <= sp_q - AW'(1);
        end
    end

    // Sticky overflow on a push into a full stack.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stack_overflow <= 1'b0;
        end else if (do_push && sp_q == AW'(DEPTH)) begin
            stack_overflow <= 1'b1;
        end
    end

    // Loop kind of the running loop, saved per level.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            kind_q   <= HLS_KIND_FOREVER;
            single_q <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                kind_save_q[i] <= HLS_KIND_FOREVER;
            end
        end else if (do_push) begin
            kind_q   <= setup_kind;
            single_q <= setup_single;
            if (!stack_empty && sp_q < AW'(DEPTH)) begin
                kind_save_q[dec_ptr(sp_q)] <= kind_q;
            end
        end else if (pop_now) begin
            kind_q   <= kind_save_q[rd_addr];
            single_q <= 1'b0;
        end
    end

    // Marks that the top must be refilled from memory one cycle after a pop.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            refill_q <= 1'b0;
        end else begin
            refill_q <= pop_now && !do_push && sp_q > AW'(1);
        end
    end

    // ****************************************************************
    // Count registers
    // ****************************************************************

    logic counter_loop;
    logic count_one;
    assign counter_loop = !stack_empty && kind_q == HLS_KIND_COUNT;
    assign count_one    = top_q == COUNT_W'(1);

    // load register changes only when loaded.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            loop_count_load <= LOAD_RESET[COUNT_W-1:0];
        end else if (loop_count_load_we) begin
            loop_count_load <= loop_count_load_wdata;
        end
    end

    // push, replace, decrement on end fetch.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            top_q <= '0;
        end else if (do_push) begin
            top_q <= loop_count_load;
        end else if (refill_q) begin
            top_q <= mem_rd;
        end else if (cur_we && counter_loop) begin
            top_q <= cur_wdata;
        end else if (counter_loop && end_fetch && !stall) begin
            // zero wraps, giving the full count range.
            top_q <= top_q - COUNT_W'(1);
        end
    end

    // current count read, empty reads all ones.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            current_loop_count <= EMPTY_READ[COUNT_W-1:0];
        end else begin
            current_loop_count <= stack_empty ? EMPTY_READ[COUNT_W-1:0] : top_q;
        end
    end

    // ****************************************************************
    // Not-expired condition
    // ****************************************************************

    logic ne_now;
    logic ne_d1_q;
    assign ne_now = counter_loop && !count_one;

    // one cycle for others, two for branches; free-running.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ne_d1_q            <= 1'b0;
            not_expired_other  <= 1'b0;
            not_expired_branch <= 1'b0;
        end else begin
            ne_d1_q            <= ne_now;
            not_expired_other  <= ne_now;
            not_expired_branch <= ne_d1_q;
        end
    end

    // ****************************************************************
    // Termination
    // ****************************************************************

    logic mult_q;
    logic arith_test;
    logic exit_now;

    // multiplier abort delayed one machine cycle.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mult_q <= 1'b0;
        end else begin
            mult_q <= mult_status_chg && !stack_empty && kind_q == HLS_KIND_ARITH;
        end
    end
    assign arith_loop_abort = mult_q;

    // several-instruction test point, single tests each cycle.
    assign arith_test = !stack_empty && kind_q == HLS_KIND_ARITH && !stall &&
                        (single_q || second_fetch);

    // forever loops never exit here; expiry at count one.
    always_comb begin
        case (kind_q)
            HLS_KIND_COUNT:   exit_now = !stack_empty && end_fetch && !stall && count_one;
            HLS_KIND_ARITH:   exit_now = (arith_test && term_cond) || mult_q;
            HLS_KIND_FOREVER: exit_now = 1'b0;
            default:          exit_now = 1'b0;
        endcase
    end

    // exit fetch, flush only on arithmetic loop exits, pop both stacks.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            loop_exit   <= 1'b0;
            flush_fetch <= 1'b0;
            pop_stacks  <= 1'b0;
        end else begin
            loop_exit   <= exit_now && !pop_stacks;
            flush_fetch <= exit_now && !pop_stacks && kind_q == HLS_KIND_ARITH;
            pop_stacks  <= exit_now && !pop_stacks;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************

    chk_empty_read: assert property (@(posedge ref_clk) disable iff (rst)
        $past(stack_empty) && !$past(rst) |-> current_loop_count == EMPTY_READ[COUNT_W-1:0])
        else $error("Empty stack read not all ones.");
    chk_empty_write: assert property (@(posedge ref_clk) disable iff (rst)
        stack_empty && cur_we && !setup_valid |=> stack_empty)
        else $error("Write on empty stack changed state.");
    chk_write_nopush: assert property (@(posedge ref_clk) disable iff (rst)
        cur_we && !setup_valid && !pop_now |=> $stable(sp_q))
        else $error("Count write moved stack.");
    chk_write_gate: assert property (@(posedge ref_clk) disable iff (rst)
        cur_we && !counter_loop && !setup_valid && !refill_q && !stack_empty |=> $stable(top_q))
        else $error("Write took effect outside counter loop.");
    chk_push_load: assert property (@(posedge ref_clk) disable iff (rst)
        setup_valid |=> top_q == $past(loop_count_load))
        else $error("Push did not load count.");
    chk_decrement: assert property (@(posedge ref_clk) disable iff (rst)
        counter_loop && end_fetch && !stall && !cur_we && !setup_valid && !refill_q
        |=> top_q == $past(top_q) - COUNT_W'(1))
        else $error("Count not decremented.");
    chk_branch_lat: assert property (@(posedge ref_clk) disable iff (rst)
        ##2 not_expired_branch == $past(ne_now, 2))
        else $error("Branch condition latency wrong.");
    chk_exit_pop: assert property (@(posedge ref_clk) disable iff (rst)
        exit_now && !pop_stacks |=> pop_stacks && loop_exit)
        else $error("Exit without pop.");
    chk_forever: assert property (@(posedge ref_clk) disable iff (rst)
        kind_q == HLS_KIND_FOREVER && !mult_q |=> !loop_exit)
        else $error("Forever loop exited.");
    chk_mult_abort: assert property (@(posedge ref_clk) disable iff (rst)
        mult_status_chg && !stack_empty && kind_q == HLS_KIND_ARITH |=> arith_loop_abort)
        else $error("Multiplier abort latency wrong.");

    cov_counter_exit: cover property (@(posedge ref_clk) counter_loop ##1 loop_exit);
    cov_arith_flush:  cover property (@(posedge ref_clk) flush_fetch);
    cov_overflow:     cover property (@(posedge ref_clk) stack_overflow);
endmodule : hls_sequencer
`default_nettype wire

// *** testbench/hardware_loop_sequencer_test.sv ***
// Self-checking testbench of the hardware loop sequencer.
`timescale 1ns/1ps
`default_nettype none
module hardware_loop_sequencer_test;
    import hls_pkg::*;

    // Clock, reset and design stimulus.
    logic                  ref_clk;
    logic                  rst;
    logic                  loop_count_load_we;
    logic [COUNT_W-1:0]    loop_count_load_wdata;
    logic                  setup_valid;
    hls_kind_e             setup_kind;
    logic                  setup_single;
    logic                  cur_we;
    logic [COUNT_W-1:0]    cur_wdata;
    logic                  stall;
    logic                  end_fetch;
    logic                  second_fetch;
    logic                  term_cond;
    logic                  mult_status_chg;
    logic                  stack_pop;
    // Design results.
    logic [COUNT_W-1:0]    loop_count_load;
    logic [COUNT_W-1:0]    current_loop_count;
    logic                  not_expired_branch;
    logic                  not_expired_other;
    logic                  loop_exit;
    logic                  flush_fetch;
    logic                  pop_stacks;
    logic                  arith_loop_abort;
    logic                  stack_empty;
    logic                  stack_overflow;
    int                    failures;
    int                    comparisons;

    hls_sequencer dut (
        .ref_clk(ref_clk), .rst(rst),
        .loop_count_load_we(loop_count_load_we), .loop_count_load_wdata(loop_count_load_wdata),
        .loop_count_load(loop_count_load), .setup_valid(setup_valid), .setup_kind(setup_kind),
        .setup_single(setup_single), .cur_we(cur_we), .cur_wdata(cur_wdata),
        .current_loop_count(current_loop_count), .stall(stall), .end_fetch(end_fetch),
        .second_fetch(second_fetch), .term_cond(term_cond), .mult_status_chg(mult_status_chg),
        .stack_pop(stack_pop), .not_expired_branch(not_expired_branch),
        .not_expired_other(not_expired_other), .loop_exit(loop_exit), .flush_fetch(flush_fetch),
        .pop_stacks(pop_stacks), .arith_loop_abort(arith_loop_abort), .stack_empty(stack_empty),
        .stack_overflow(stack_overflow)
    );

    // Free-running core clock of 40 ns.
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ******************************************
    // Compare and drive helpers
    // ******************************************
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick

    // Holds reset for five cycles; inputs settle at the falling edge.
    task automatic do_reset();
        rst = 1'b1;
        tick(5);
        rst = 1'b0;
        tick(1);
    endtask : do_reset

    // One-cycle pulses on the pipeline event inputs.
    // clean end fetch.
    task automatic fire(input logic e, input logic s, input logic m, input logic p);
        end_fetch = e;
        second_fetch = s;
        mult_status_chg = m;
        stack_pop = p;
        tick(1);
        {end_fetch, second_fetch, mult_status_chg, stack_pop} = 4'h0;
    endtask : fire

    // Loads the count register and then sets up a loop of the given kind.
    task automatic setup(input hls_kind_e k, input logic one, input logic [31:0] cnt);
        loop_count_load_we = 1'b1;
        loop_count_load_wdata = cnt;
        tick(1);
        loop_count_load_we = 1'b0;
        setup_valid = 1'b1;
        setup_kind = k;
        setup_single = one;
        tick(1);
        setup_valid = 1'b0;
        tick(2);
    endtask : setup

    task automatic write_cur(input logic [31:0] v);
        cur_we = 1'b1;
        cur_wdata = v;
        tick(1);
        cur_we = 1'b0;
        tick(2);
    endtask : write_cur

    // Waits a bounded span for an exit and judges the companion pulses.
    task automatic wait_exit(input logic flush_exp);
        int i;
        for (i = 0; i < 6 && loop_exit !== 1'b1; i++) tick(1);
        chk_bit(loop_exit, 1'b1);
        chk_bit(pop_stacks, 1'b1);
        chk_bit(flush_fetch, flush_exp);
        tick(2);
    endtask : wait_exit

    // Watches a span during which no exit may appear.
    task automatic no_exit(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            tick(1);
            seen |= loop_exit;
        end
        chk_bit(seen, 1'b0);
    endtask : no_exit

    // ******************************************
    // Scenarios
    // ******************************************
    task automatic test_empty();
        do_reset();
        chk_val(current_loop_count, EMPTY_READ);
        chk_bit(stack_empty, 1'b1);
        write_cur(32'h0000_0007);
        chk_val(current_loop_count, EMPTY_READ);
        chk_bit(stack_empty, 1'b1);
    endtask : test_empty

    task automatic test_count_loop();
        do_reset();
        setup(HLS_KIND_COUNT, 1'b0, 32'h0000_0003);
        chk_val(current_loop_count, 32'h0000_0003);
        chk_bit(not_expired_other, 1'b1);
        chk_bit(not_expired_branch, 1'b1);
        fire(1'b1, 1'b0, 1'b0, 1'b0);
        no_exit(2);
        chk_val(current_loop_count, 32'h0000_0002);
        stall = 1'b1;
        fire(1'b1, 1'b0, 1'b0, 1'b0);
        stall = 1'b0;
        no_exit(2);
        chk_val(current_loop_count, 32'h0000_0002);
        fire(1'b1, 1'b0, 1'b0, 1'b0);
        no_exit(1);
        chk_bit(not_expired_other, 1'b0);
        chk_bit(not_expired_branch, 1'b1);
        no_exit(1);
        chk_bit(not_expired_branch, 1'b0);
        chk_val(loop_count_load, 32'h0000_0003);
        fire(1'b1, 1'b0, 1'b0, 1'b0);
        wait_exit(1'b0);
        chk_bit(stack_empty, 1'b1);
    endtask : test_count_loop

    task automatic test_cur_write();
        do_reset();
        setup(HLS_KIND_COUNT, 1'b0, 32'h0000_0005);
        write_cur(32'h0000_0002);
        chk_val(current_loop_count, 32'h0000_0002);
        fire(1'b1, 1'b0, 1'b0, 1'b0);
        no_exit(2);
        fire(1'b1, 1'b0, 1'b0, 1'b0);
        wait_exit(1'b0);
        chk_bit(stack_empty, 1'b1);
    endtask : test_cur_write

    task automatic test_arith();
        int i;
        logic [1:0] hits;
        do_reset();
        setup(HLS_KIND_ARITH, 1'b0, 32'h0000_0004);
        write_cur(32'h0000_0009);
        chk_val(current_loop_count, 32'h0000_0004);
        term_cond = 1'b1;
        no_exit(3);
        fire(1'b0, 1'b1, 1'b0, 1'b0);
        term_cond = 1'b0;
        wait_exit(1'b1);
        do_reset();
        setup(HLS_KIND_ARITH, 1'b0, 32'h0000_0004);
        fire(1'b0, 1'b1, 1'b0, 1'b0);
        no_exit(3);
        chk_bit(stack_empty, 1'b0);
        hits = 2'h0;
        mult_status_chg = 1'b1;
        tick(1);
        mult_status_chg = 1'b0;
        for (i = 0; i < 3; i++) begin
            hits += {1'b0, arith_loop_abort};
            tick(1);
        end
        chk_val({30'h0, hits}, 32'h0000_0001);
        do_reset();
        setup(HLS_KIND_ARITH, 1'b1, 32'h0000_0004);
        term_cond = 1'b1;
        wait_exit(1'b1);
        term_cond = 1'b0;
    endtask : test_arith

    task automatic test_forever();
        do_reset();
        setup(HLS_KIND_FOREVER, 1'b0, 32'h0000_0001);
        term_cond = 1'b1;
        end_fetch = 1'b1;
        second_fetch = 1'b1;
        tick(4);
        {end_fetch, second_fetch} = 2'h0;
        no_exit(4);
        term_cond = 1'b0;
        chk_bit(stack_empty, 1'b0);
        do_reset();
        chk_bit(stack_empty, 1'b1);
    endtask : test_forever

    task automatic test_depth();
        int i;
        do_reset();
        for (i = 1; i <= STACK_DEPTH; i++) setup(HLS_KIND_COUNT, 1'b0, i);
        chk_bit(stack_overflow, 1'b0);
        setup(HLS_KIND_COUNT, 1'b0, 32'h0000_0077);
        chk_bit(stack_overflow, 1'b1);
        // A push into a full stack flags overflow and replaces the top count.
        chk_val(current_loop_count, 32'h0000_0077);
        fire(1'b0, 1'b0, 1'b0, 1'b1);
        tick(2);
        chk_val(current_loop_count, STACK_DEPTH - 1);
        for (i = 1; i < STACK_DEPTH; i++) begin
            fire(1'b0, 1'b0, 1'b0, 1'b1);
            tick(1);
        end
        tick(1);
        chk_val(current_loop_count, EMPTY_READ);
        chk_bit(stack_overflow, 1'b1);
    endtask : test_depth

    task automatic test_zero();
        do_reset();
        setup(HLS_KIND_COUNT, 1'b0, 32'h0000_0000);
        end_fetch = 1'b1;
        tick(3);
        end_fetch = 1'b0;
        no_exit(3);
        chk_val(current_loop_count, 32'hffff_fffd);
    endtask : test_zero

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // Main sequence; all inputs are given values at time zero.
    initial begin
        failures = 0;
        comparisons = 0;
        rst = 1'b1;
        {loop_count_load_we, setup_valid, setup_single, cur_we, stall} = 5'h0;
        {end_fetch, second_fetch, term_cond, mult_status_chg, stack_pop} = 5'h0;
        loop_count_load_wdata = 32'h0;
        cur_wdata = 32'h0;
        setup_kind = HLS_KIND_COUNT;
        test_empty();
        test_count_loop();
        test_cur_write();
        test_arith();
        test_forever();
        test_depth();
        test_zero();
        final_report();
    end

    // Watchdog: the scenarios need well under 1000 cycles.
    initial begin
        #200us;
        failures++;
        final_report();
    end
endmodule : hardware_loop_sequencer_test
`default_nettype wire
